// File: sysctl_pkg.sv
// Package of constants and types shared by the processor sideband end and the system controller end.
// Contract
// - Error alert rises on any detected error.
// - Alert may request controller action during init.
// - Error alert holds until software clears cause.
// - Low halt request forces checkstop condition.
// - Fatal error output low on unrecoverable error.
// - Fatal error holds until software clears checkstop.
// - Reset input low during power-on, resets device.
// - Supply good low first, then high steadily.
// - Internal time base: gate high enables counting.
// - External time base: gate carries 20-286 MHz clock; the device samples it on clk_sys and counts it only well below half of clk_sys.
// - Overtemp alarm rises when sensor exceeds limit.
// - Overtemp alarm follows condition, self releasing.
// - Alert outputs asynchronous; controller synchronises them.
`default_nettype none
package sysctl_pkg;
	// ****************************************************************
	// Widths and counts
	// ****************************************************************
	localparam int SYNC_STAGES = 2;
	localparam int TB_WIDTH = 64;
	localparam int SENSOR_COUNT = 4;
	localparam int CLK_PERIOD_NS = 10;
	localparam int EXT_TB_MIN_KHZ = 20000;
	localparam int EXT_TB_MAX_KHZ = 286000;
	// Power-on hold times, in ns and in controller clock cycles.
	localparam int SUPPLY_WAIT_NS = 1000;
	localparam int SUPPLY_WAIT_CYC = (SUPPLY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_HOLD_NS = 1000;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_CNT_W = 8;
	localparam logic [TB_WIDTH-1:0] TB_RESET = 64'h0000_0000_0000_0000;
	// ****************************************************************
	// Controller power-on states
	// ****************************************************************
	typedef enum logic [1:0] {
		POR_OFF = 2'b00,
		POR_SUPPLY = 2'b01,
		POR_RUN = 2'b11
	} por_state_type;
endpackage
`default_nettype wire

// File: sysctl_if.sv
// Interface carrying the sideband pins between the processor and the system controller.
`default_nettype none
interface sysctl_if;
	logic error_alert_out;
	logic fatal_error_out_n;
	logic overtemp_alarm;
	logic halt_request_in_n;
	logic ext_reset_n;
	logic supply_ok;
	logic timebase_gate;
	modport dev (
		output error_alert_out,
		output fatal_error_out_n,
		output overtemp_alarm,
		input halt_request_in_n,
		input ext_reset_n,
		input supply_ok,
		input timebase_gate
	);
	modport ctl (
		input error_alert_out,
		input fatal_error_out_n,
		input overtemp_alarm,
		output halt_request_in_n,
		output ext_reset_n,
		output supply_ok,
		output timebase_gate
	);
endinterface
`default_nettype wire

// File: sysctl_device.sv
// Processor end: error, checkstop and thermal alerts, input synchronisers and time base.
`default_nettype none
module sysctl_device (
	// Clock and local reset
	input wire logic clk_sys,
	input wire logic srst,
	// Sideband pins
	sysctl_if.dev pins,
	// Core error sources
	input wire logic error_event,
	input wire logic init_request,
	input wire logic error_clear,
	input wire logic fatal_event,
	input wire logic fatal_clear,
	input wire logic [sysctl_pkg::SENSOR_COUNT-1:0] sensor_over,
	// Time base configuration and state
	input wire logic tb_external,
	output logic [sysctl_pkg::TB_WIDTH-1:0] tb_value,
	// Status seen by the core
	output logic core_reset,
	output logic supply_stable,
	output logic checkstop
);
	import sysctl_pkg::*;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// Column 0 of each chain is read only by column 1.
	logic [SYNC_STAGES-1:0] halt_s_r, rst_s_r, sup_s_r, tbg_s_r;
	logic [SYNC_STAGES-1:0] halt_s_nxt, rst_s_nxt, sup_s_nxt, tbg_s_nxt;
	always_comb begin
		halt_s_nxt = {halt_s_r[SYNC_STAGES-2:0], pins.halt_request_in_n};
		rst_s_nxt = {rst_s_r[SYNC_STAGES-2:0], pins.ext_reset_n};
		sup_s_nxt = {sup_s_r[SYNC_STAGES-2:0], pins.supply_ok};
		tbg_s_nxt = {tbg_s_r[SYNC_STAGES-2:0], pins.timebase_gate};
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			halt_s_r <= '1;
			rst_s_r <= '0;
			sup_s_r <= '0;
			tbg_s_r <= '0;
		end else begin
			halt_s_r <= halt_s_nxt;
			rst_s_r <= rst_s_nxt;
			sup_s_r <= sup_s_nxt;
			tbg_s_r <= tbg_s_nxt;
		end
	end
	logic halt_sync, ext_rst_sync_n, tbg_sync;
	assign halt_sync = ~halt_s_r[SYNC_STAGES-1];
	assign ext_rst_sync_n = rst_s_r[SYNC_STAGES-1];
	assign tbg_sync = tbg_s_r[SYNC_STAGES-1];
	assign supply_stable = sup_s_r[SYNC_STAGES-1];
	// The core stays in reset until the reset pin is released.
	assign core_reset = srst | ~ext_rst_sync_n;

	// ****************************************************************
	// Sticky error and fatal alerts; overtemp alarm follows the sensors
	// ****************************************************************
	logic alert_r, alert_nxt, fatal_r, fatal_nxt, ot_r, ot_nxt;
	always_comb begin
		// A new cause in the clearing cycle keeps the flag set.
		alert_nxt = alert_r;
		if (error_clear)
			alert_nxt = 1'b0;
		if (error_event | init_request)
			alert_nxt = 1'b1;
		fatal_nxt = fatal_r;
		if (fatal_clear)
			fatal_nxt = 1'b0;
		if (fatal_event | halt_sync)
			fatal_nxt = 1'b1;
		ot_nxt = |sensor_over;
	end
	always_ff @(posedge clk_sys) begin
		if (core_reset) begin
			alert_r <= 1'b0;
			fatal_r <= 1'b0;
			ot_r <= 1'b0;
		end else begin
			alert_r <= alert_nxt;
			fatal_r <= fatal_nxt;
			ot_r <= ot_nxt;
		end
	end
	// Outputs change on the core clock, asynchronous to the controller.
	assign pins.error_alert_out = alert_r;
	assign pins.fatal_error_out_n = ~fatal_r;
	assign pins.overtemp_alarm = ot_r;
	assign checkstop = fatal_r;

	// ****************************************************************
	// Time base
	// ****************************************************************
	// In external mode the gate is a clock sampled here; it must stay well below half of clk_sys.
	logic tbg_d_r, tbg_d_nxt;
	logic [TB_WIDTH-1:0] tb_r, tb_nxt;
	always_comb begin
		tbg_d_nxt = tbg_sync;
		tb_nxt = tb_r;
		if (tb_external) begin
			if (tbg_sync & ~tbg_d_r)
				tb_nxt = tb_r + 64'h0000_0000_0000_0001;
		end else if (tbg_sync) begin
			tb_nxt = tb_r + 64'h0000_0000_0000_0001;
		end
		if (checkstop)
			tb_nxt = tb_r;
	end
	always_ff @(posedge clk_sys) begin
		if (core_reset) begin
			tbg_d_r <= 1'b0;
			tb_r <= TB_RESET;
		end else begin
			tbg_d_r <= tbg_d_nxt;
			tb_r <= tb_nxt;
		end
	end
	assign tb_value = tb_r;
endmodule
`default_nettype wire

// File: sysctl_controller.sv
// System controller end: power-on sequence, halt request, time base gate and synchronised alerts.
`default_nettype none
module sysctl_controller (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Sideband pins
	sysctl_if.ctl pins,
	// User side
	input wire logic halt_request,
	input wire logic tb_gate_in,
	output sysctl_pkg::por_state_type por_state,
	output logic error_alert,
	output logic fatal_error,
	output logic overtemp
);
	import sysctl_pkg::*;

	// ****************************************************************
	// Power-on sequence
	// ****************************************************************
	por_state_type st_r, st_nxt;
	logic [POR_CNT_W-1:0] cnt_r, cnt_nxt;
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r + 8'h01;
		unique case (st_r)
			POR_OFF: if (cnt_r == POR_CNT_W'(SUPPLY_WAIT_CYC - 1)) begin
				st_nxt = POR_SUPPLY;
				cnt_nxt = '0;
			end
			POR_SUPPLY: if (cnt_r == POR_CNT_W'(RESET_HOLD_CYC - 1)) begin
				st_nxt = POR_RUN;
				cnt_nxt = '0;
			end
			POR_RUN: cnt_nxt = '0;
			default: begin
				st_nxt = POR_OFF;
				cnt_nxt = '0;
			end
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= POR_OFF;
			cnt_r <= '0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	assign por_state = st_r;
	assign pins.supply_ok = (st_r != POR_OFF);
	assign pins.ext_reset_n = (st_r == POR_RUN);
	assign pins.halt_request_in_n = ~(halt_request & (st_r == POR_RUN));
	assign pins.timebase_gate = tb_gate_in;

	// ****************************************************************
	// Alert synchronisers
	// ****************************************************************
	logic [2:0] s1_r, s2_r, s1_nxt, s2_nxt;
	always_comb begin
		s1_nxt = {pins.overtemp_alarm, ~pins.fatal_error_out_n, pins.error_alert_out};
		s2_nxt = s1_r;
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end
	assign error_alert = s2_r[0];
	assign fatal_error = s2_r[1];
	assign overtemp = s2_r[2];
endmodule
`default_nettype wire

// File: sysctl_props.sv
// Checker of the sideband pins between the processor end and the controller end.
`default_nettype none
module sysctl_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Sideband pins
	input wire logic error_alert_out,
	input wire logic fatal_error_out_n,
	input wire logic overtemp_alarm,
	input wire logic halt_request_in_n,
	input wire logic ext_reset_n,
	input wire logic supply_ok,
	input wire logic timebase_gate
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Pin relations
	// ****
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	supply_first_a: assert property (ext_reset_n |-> supply_ok) else $error("reset released early");
	supply_steady_a: assert property (supply_ok |=> supply_ok) else $error("supply good dropped");
	supply_rise_a: assert property ($rose(supply_ok) |-> !ext_reset_n) else $error("supply rose late");
	reset_steady_a: assert property (ext_reset_n |=> ext_reset_n) else $error("reset reasserted");
	// A held reset must keep every alert quiet once the synchronisers have flushed.
	reset_quiet_a: assert property (!ext_reset_n [*4] |->
		!error_alert_out && fatal_error_out_n && !overtemp_alarm) else $error("alert during reset");
	halt_fatal_a: assert property ((!halt_request_in_n && ext_reset_n) [*4] |-> !fatal_error_out_n)
		else $error("halt not seen");
	// A halt that has crossed the synchroniser re-sets the flag, so a clear in that cycle cannot release it.
	fatal_hold_a: assert property ((!halt_request_in_n && ext_reset_n) [*3] ##0 !fatal_error_out_n
		|=> !fatal_error_out_n) else $error("fatal released");
	halt_idle_a: assert property (!ext_reset_n |-> halt_request_in_n) else $error("halt during reset");
endmodule
`default_nettype wire

// File: test_system_error_reset_signals.sv
// Testbench joining both ends, with a reference model of the alerts.
`default_nettype none
module test_system_error_reset_signals;
	timeunit 1ns;
	timeprecision 1ps;
	import sysctl_pkg::*;
	logic clk_sys = 0, srst = 1, ev = 0, ir = 0, ec = 0, fe = 0, fc = 0, tbx = 0, hr = 0, tg = 0;
	logic [3:0] so = 0;
	logic [63:0] tbv, t0;
	logic [31:0] rs = 32'h0000_6cc3, r;
	logic crst, sst, cks, ea, fa, ot;
	por_state_type ps;
	int error_cnt = 0, total_checks = 0, m_e = 0, m_f = 0;
	int qe[$] = '{0, 0}, qf[$] = '{0, 0}, qo[$] = '{0, 0};
	always #5 clk_sys = ~clk_sys;
	sysctl_if sysctl_if_i();
	sysctl_device sysctl_device_i (.clk_sys(clk_sys), .srst(srst), .pins(sysctl_if_i), .error_event(ev),
		.init_request(ir), .error_clear(ec), .fatal_event(fe), .fatal_clear(fc), .sensor_over(so),
		.tb_external(tbx), .tb_value(tbv), .core_reset(crst), .supply_stable(sst), .checkstop(cks));
	sysctl_controller sysctl_controller_i (.clk_sys(clk_sys), .srst(srst), .pins(sysctl_if_i),
		.halt_request(hr), .tb_gate_in(tg), .por_state(ps), .error_alert(ea), .fatal_error(fa), .overtemp(ot));
	sysctl_props sysctl_props_i (.clk_sys(clk_sys), .srst(srst), .error_alert_out(sysctl_if_i.error_alert_out),
		.fatal_error_out_n(sysctl_if_i.fatal_error_out_n), .overtemp_alarm(sysctl_if_i.overtemp_alarm),
		.halt_request_in_n(sysctl_if_i.halt_request_in_n), .ext_reset_n(sysctl_if_i.ext_reset_n),
		.supply_ok(sysctl_if_i.supply_ok), .timebase_gate(sysctl_if_i.timebase_gate));
	function logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task results();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		// An error cause held through power-on must not reach the pin.
		ev = 1;
		cyc(6);
		srst = 0;
		for (int i = 0; i < 400 && ps !== POR_RUN; i++) begin
			cyc(1);
			if (i > 3 && sysctl_if_i.ext_reset_n === 1'b0) chk(sysctl_if_i.error_alert_out, 0);
		end
		if (ps !== POR_RUN) begin
			error_cnt++;
			results();
		end else begin
			ev = 0;
			ec = 1;
			fc = 1;
			cyc(6);
			ec = 0;
			fc = 0;
			chk(sst, 1);
			chk(crst, 0);
			$display("test power-on done");
			for (int i = 0; i < 2000; i++) begin
				r = rnd();
				ev = r[3:0] == 0;
				ir = r[7:4] == 0;
				ec = r[9:8] == 0;
				fe = r[14:10] == 0;
				fc = r[16:15] == 0;
				so = r[20:17] == 0 ? r[24:21] : 4'h0;
				cyc(1);
				m_e = ev | ir | (m_e & !ec);
				m_f = fe | (m_f & !fc);
				qe.push_back(m_e);
				qf.push_back(m_f);
				qo.push_back(|so);
				chk(sysctl_if_i.error_alert_out, m_e);
				chk(!sysctl_if_i.fatal_error_out_n, m_f);
				chk(sysctl_if_i.overtemp_alarm, |so);
				chk(ea, qe[$-2]);
				chk(fa, qf[$-2]);
				chk(ot, qo[$-2]);
			end
			$display("test random alerts done");
			{ev, ir, fe, so} = 0;
			fc = 1;
			cyc(4);
			fc = 0;
			t0 = tbv;
			tg = 1;
			cyc(50);
			tg = 0;
			cyc(5);
			chk(tbv - t0, 50);
			tbx = 1;
			cyc(4);
			t0 = tbv;
			repeat (10) begin
				tg = 1;
				cyc(2);
				tg = 0;
				cyc(2);
			end
			cyc(5);
			chk(tbv - t0, 10);
			tbx = 0;
			$display("test time base done");
			hr = 1;
			cyc(8);
			chk(cks, 1);
			fc = 1;
			cyc(2);
			fc = 0;
			chk(fa, 1);
			hr = 0;
			cyc(6);
			chk(fa, 1);
			fc = 1;
			cyc(2);
			fc = 0;
			cyc(3);
			chk(fa, 0);
			$display("test halt done");
			results();
		end
	end
endmodule
`default_nettype wire
